// >>> icvd_pkg.sv
// package for the init/config register bank: bit positions, reset values, refresh figures
// assumes a host write port that already decodes which of the two registers is addressed
//
// Notes on behaviour
// R1: writes ignored unless config write gate set
// R2: writes apply at once, bypassing host FIFO
// R3: bit0 reports latched pci function arrangement
// R4: bit1 write wait states, resets to one
// R5: bit2 reports one or two accelerators
// R6: bit3 enables frame buffer reads, resets zero
// R7: bits7:4 tile count halved, resets zero
// R8: bit8 holds video timing in reset
// R9: bit9 overrides syncs with bits 10,11
// R10: bit12 blanks monitor, resets to one
// R11: bits13-16 enable outputs, tristate at reset
// R12: clock input select and source select
// R13: three two-bit clock delay selects
// R14: bit26 inverts double-rate video clock
// R15: bits22,23,25 enable 24bpp, interleave, filter
// R16: bit31 disables fast read-ahead turnaround
// R17: second register dither subtract, pass-through dither
// R18: banking size bit1, banking enable bit20
// R19: bit4 enables triple buffering
// R20: ras, oe, turnaround, read-ahead fifo enables
// R21: bits10:9 choose swap trigger source
// R22: bits19:11 hold video buffer offset
// R23: refresh enable and nine-bit counter load
// R24: reload on expiry, one refresh request each
package icvd_pkg;
    // ---------------------------------------------------------------
    // register select and reset values
    // ---------------------------------------------------------------
    localparam logic icvd_sel_pci_video = 1'b0;
    localparam logic icvd_sel_dram = 1'b1;
    // bits 0 and 2 are status, reset value shows stored bits only
    localparam logic [31:0] icvd_pvi_reset = 32'h0020_1102;
    localparam logic [31:0] icvd_pvi_rw_mask = 32'hfeff_fffa;
    localparam logic [31:0] icvd_dram_reset = 32'h8000_0040;
    localparam logic [31:0] icvd_dram_rw_mask = 32'hffff_fff3;
    // ---------------------------------------------------------------
    // field positions, first register
    // ---------------------------------------------------------------
    localparam int icvd_b_func = 0;
    localparam int icvd_b_wait = 1;
    localparam int icvd_b_multi = 2;
    localparam int icvd_b_lfb_rd = 3;
    localparam int icvd_b_tiles_lo = 4;
    localparam int icvd_b_tiles_hi = 7;
    localparam int icvd_b_vt_rst = 8;
    localparam int icvd_b_sync_ovr = 9;
    localparam int icvd_b_hsync_val = 10;
    localparam int icvd_b_vsync_val = 11;
    localparam int icvd_b_blank = 12;
    localparam int icvd_b_drv_lo = 13;
    localparam int icvd_b_drv_hi = 16;
    localparam int icvd_b_vclk_in = 17;
    localparam int icvd_b_dly2x_lo = 18;
    localparam int icvd_b_src_lo = 20;
    localparam int icvd_b_bpp24 = 22;
    localparam int icvd_b_sli = 23;
    localparam int icvd_b_filter = 25;
    localparam int icvd_b_invert = 26;
    localparam int icvd_b_dlysel_lo = 27;
    localparam int icvd_b_dlyclk_lo = 29;
    localparam int icvd_b_no_fast_rar = 31;
    // ---------------------------------------------------------------
    // field positions, second register
    // ---------------------------------------------------------------
    localparam int icvd_b_dith_sub = 0;
    localparam int icvd_b_bank_size = 1;
    localparam int icvd_b_triple = 4;
    localparam int icvd_b_fast_ras = 5;
    localparam int icvd_b_gen_oe = 6;
    localparam int icvd_b_fast_raw = 7;
    localparam int icvd_b_pass_dith = 8;
    localparam int icvd_b_swap_lo = 9;
    localparam int icvd_b_swap_hi = 10;
    localparam int icvd_b_offs_lo = 11;
    localparam int icvd_b_offs_hi = 19;
    localparam int icvd_b_bank_en = 20;
    localparam int icvd_b_ra_fifo = 21;
    localparam int icvd_b_refr_en = 22;
    localparam int icvd_b_refr_lo = 23;
    localparam int icvd_b_refr_hi = 31;
    // ---------------------------------------------------------------
    // refresh counter shape
    // ---------------------------------------------------------------
    localparam int icvd_refr_width = 14;
    localparam int icvd_refr_low_bits = 5;
    localparam logic [4:0] icvd_refr_low_zero = 5'h00;
    localparam logic [13:0] icvd_refr_zero = 14'h0000;
    localparam logic [13:0] icvd_refr_one = 14'h0001;
endpackage

// >>> icvd_init_config.sv
// register bank for the pci/video and dram init registers with refresh timer
// assumes write/read strobes are synchronous to clk; strap and detect pins are asynchronous
`timescale 1ns/1ps
module icvd_init_config
    import icvd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // host register port
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic host_sel,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    // pci configuration gate
    input wire logic init_register_write_gate,
    // straps and detection pins
    input wire logic func_strap_pin,
    input wire logic multi_chip_pin,
    // pci controller controls
    output logic pci_write_wait,
    output logic lfb_read_enable,
    output logic no_fast_rar_turnaround,
    // video timing controls
    input wire logic timing_hsync,
    input wire logic timing_vsync,
    input wire logic timing_blank,
    output logic [3:0] tiles_x_half,
    output logic video_timing_reset,
    output logic hsync_out,
    output logic vsync_out,
    output logic blank_out,
    output logic video_data_oe,
    output logic blank_oe,
    output logic sync_oe,
    output logic dot_clock_oe,
    output logic vclk_input_slave,
    output logic [1:0] vclk_source,
    output logic [1:0] double_rate_video_clock_delay,
    output logic [1:0] selected_double_rate_clock_delay,
    output logic [1:0] video_clock_delay,
    output logic invert_double_rate_video_clock,
    output logic bpp24_enable,
    output logic interleave_enable,
    output logic edge_filter_enable,
    // dram controller controls
    output logic dither_subtract_enable,
    output logic bank_size_256k,
    output logic triple_buffer_enable,
    output logic fast_ras_enable,
    output logic gen_oe_enable,
    output logic fast_raw_turnaround,
    output logic pass_dither_enable,
    output logic [1:0] swap_source,
    output logic [8:0] video_buffer_offset,
    output logic bank_enable,
    output logic read_ahead_fifo_enable,
    output logic refresh_request
);
    // ---------------------------------------------------------------
    // pin synchronisers and straps
    // ---------------------------------------------------------------
    logic func_meta_reg, func_sync_reg;
    logic multi_meta_reg, multi_sync_reg;
    logic strap_taken_reg, func_latched_reg;

    always_ff @(posedge clk) begin
        func_meta_reg <= func_strap_pin;
        func_sync_reg <= func_meta_reg;
        multi_meta_reg <= multi_chip_pin;
        multi_sync_reg <= multi_meta_reg;
    end

    // arrangement is captured once after reset release, later pin motion ignored
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            strap_taken_reg <= 1'b0;
            func_latched_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            func_latched_reg <= func_sync_reg; // [R3]
        end
    end

    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------
    logic [31:0] pvi_reg, pvi_next;
    logic [31:0] dram_reg, dram_next;
    wire wr_ok = host_wr && init_register_write_gate; // [R1]
    wire wr_pvi = wr_ok && (host_sel == icvd_sel_pci_video);
    wire wr_dram = wr_ok && (host_sel == icvd_sel_dram);

    // no fifo on this path: the value lands on the next edge [R2]
    assign pvi_next = wr_pvi ? (host_wdata & icvd_pvi_rw_mask) : pvi_reg;
    assign dram_next = wr_dram ? (host_wdata & icvd_dram_rw_mask) : dram_reg;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pvi_reg <= icvd_pvi_reset; // [R4] [R8] [R10] [R12]
            dram_reg <= icvd_dram_reset; // [R20] [R23]
        end else begin
            pvi_reg <= pvi_next;
            dram_reg <= dram_next;
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    logic [31:0] pvi_view;
    always_comb begin
        pvi_view = pvi_reg;
        pvi_view[icvd_b_func] = func_latched_reg; // [R3]
        pvi_view[icvd_b_multi] = multi_sync_reg; // [R5]
    end
    wire [31:0] rd_mux = (host_sel == icvd_sel_dram) ? dram_reg : pvi_view;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            host_rdata <= 32'h0000_0000;
        end else if (host_rd) begin
            host_rdata <= rd_mux;
        end
    end

    // ---------------------------------------------------------------
    // video sync and blank selection
    // ---------------------------------------------------------------
    wire ovr = pvi_reg[icvd_b_sync_ovr];
    wire hs_d = ovr ? pvi_reg[icvd_b_hsync_val] : timing_hsync; // [R9]
    wire vs_d = ovr ? pvi_reg[icvd_b_vsync_val] : timing_vsync; // [R9]
    wire bl_d = pvi_reg[icvd_b_blank] | timing_blank; // [R10]

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hsync_out <= 1'b0;
        end else begin
            hsync_out <= hs_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vsync_out <= 1'b0;
        end else begin
            vsync_out <= vs_d;
        end
    end

    // blank is held through reset so the monitor never sees a stray frame
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            blank_out <= 1'b1;
        end else begin
            blank_out <= bl_d;
        end
    end

    // ---------------------------------------------------------------
    // field decode, first register
    // ---------------------------------------------------------------
    wire wait_d = pvi_reg[icvd_b_wait]; // [R4]
    wire lfb_d = pvi_reg[icvd_b_lfb_rd]; // [R6]
    wire [3:0] tiles_d = pvi_reg[icvd_b_tiles_hi:icvd_b_tiles_lo]; // [R7]
    wire vt_rst_d = pvi_reg[icvd_b_vt_rst]; // [R8]
    wire data_oe_d = pvi_reg[icvd_b_drv_lo]; // [R11]
    wire blank_oe_d = pvi_reg[icvd_b_drv_lo+1];
    wire sync_oe_d = pvi_reg[icvd_b_drv_lo+2];
    wire dclk_oe_d = pvi_reg[icvd_b_drv_hi];
    wire vclk_in_d = pvi_reg[icvd_b_vclk_in]; // [R12]
    wire [1:0] vclk_src_d = pvi_reg[icvd_b_src_lo+:2];
    wire [1:0] dly2x_d = pvi_reg[icvd_b_dly2x_lo+:2]; // [R13]
    wire [1:0] dlysel_d = pvi_reg[icvd_b_dlysel_lo+:2];
    wire [1:0] dlyclk_d = pvi_reg[icvd_b_dlyclk_lo+:2];
    wire invert_d = pvi_reg[icvd_b_invert]; // [R14]
    wire bpp24_d = pvi_reg[icvd_b_bpp24]; // [R15]
    wire interleave_d = pvi_reg[icvd_b_sli];
    wire filter_d = pvi_reg[icvd_b_filter];
    wire no_fast_rar_d = pvi_reg[icvd_b_no_fast_rar]; // [R16]

    // ---------------------------------------------------------------
    // field decode, second register
    // ---------------------------------------------------------------
    wire dith_sub_d = dram_reg[icvd_b_dith_sub]; // [R17]
    wire pass_dith_d = dram_reg[icvd_b_pass_dith];
    wire bank_size_d = dram_reg[icvd_b_bank_size]; // [R18]
    wire bank_en_d = dram_reg[icvd_b_bank_en];
    wire triple_d = dram_reg[icvd_b_triple]; // [R19]
    wire fast_ras_d = dram_reg[icvd_b_fast_ras]; // [R20]
    wire gen_oe_d = dram_reg[icvd_b_gen_oe];
    // software must keep oe on; gating here avoids a bad turnaround anyway
    wire fast_raw_d = dram_reg[icvd_b_fast_raw] & gen_oe_d; // [R20]
    wire ra_fifo_d = dram_reg[icvd_b_ra_fifo];
    wire [1:0] swap_d = dram_reg[icvd_b_swap_hi:icvd_b_swap_lo]; // [R21]
    wire [8:0] offs_d = dram_reg[icvd_b_offs_hi:icvd_b_offs_lo]; // [R22]

    // ---------------------------------------------------------------
    // control outputs, one flop per field, one edge behind the register
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        pci_write_wait <= wait_d;
    end

    always_ff @(posedge clk) begin
        lfb_read_enable <= lfb_d;
    end

    always_ff @(posedge clk) begin
        tiles_x_half <= tiles_d;
    end

    always_ff @(posedge clk) begin
        video_timing_reset <= vt_rst_d;
    end

    always_ff @(posedge clk) begin
        video_data_oe <= data_oe_d;
    end

    always_ff @(posedge clk) begin
        blank_oe <= blank_oe_d;
    end

    always_ff @(posedge clk) begin
        sync_oe <= sync_oe_d;
    end

    always_ff @(posedge clk) begin
        dot_clock_oe <= dclk_oe_d;
    end

    always_ff @(posedge clk) begin
        vclk_input_slave <= vclk_in_d;
    end

    always_ff @(posedge clk) begin
        vclk_source <= vclk_src_d;
    end

    always_ff @(posedge clk) begin
        double_rate_video_clock_delay <= dly2x_d;
    end

    always_ff @(posedge clk) begin
        selected_double_rate_clock_delay <= dlysel_d;
    end

    always_ff @(posedge clk) begin
        video_clock_delay <= dlyclk_d;
    end

    always_ff @(posedge clk) begin
        invert_double_rate_video_clock <= invert_d;
    end

    always_ff @(posedge clk) begin
        bpp24_enable <= bpp24_d;
    end

    always_ff @(posedge clk) begin
        interleave_enable <= interleave_d;
    end

    always_ff @(posedge clk) begin
        edge_filter_enable <= filter_d;
    end

    always_ff @(posedge clk) begin
        no_fast_rar_turnaround <= no_fast_rar_d;
    end

    always_ff @(posedge clk) begin
        dither_subtract_enable <= dith_sub_d;
    end

    always_ff @(posedge clk) begin
        pass_dither_enable <= pass_dith_d;
    end

    always_ff @(posedge clk) begin
        bank_size_256k <= bank_size_d;
    end

    always_ff @(posedge clk) begin
        bank_enable <= bank_en_d;
    end

    always_ff @(posedge clk) begin
        triple_buffer_enable <= triple_d;
    end

    always_ff @(posedge clk) begin
        fast_ras_enable <= fast_ras_d;
    end

    always_ff @(posedge clk) begin
        gen_oe_enable <= gen_oe_d;
    end

    always_ff @(posedge clk) begin
        fast_raw_turnaround <= fast_raw_d;
    end

    always_ff @(posedge clk) begin
        read_ahead_fifo_enable <= ra_fifo_d;
    end

    always_ff @(posedge clk) begin
        swap_source <= swap_d;
    end

    always_ff @(posedge clk) begin
        video_buffer_offset <= offs_d;
    end

    // ---------------------------------------------------------------
    // refresh timer
    // ---------------------------------------------------------------
    logic [13:0] refr_cnt_reg, refr_cnt_next;
    wire refr_on = dram_reg[icvd_b_refr_en]; // [R23]
    wire [13:0] refr_load = {dram_reg[icvd_b_refr_hi:icvd_b_refr_lo], icvd_refr_low_zero};
    wire refr_expire = refr_on && (refr_cnt_reg == icvd_refr_zero);

    // counter reloads while disabled so enabling starts a full period
    assign refr_cnt_next = (!refr_on || refr_expire) ? refr_load
                         : refr_cnt_reg - icvd_refr_one; // [R24]

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            refr_cnt_reg <= {icvd_dram_reset[icvd_b_refr_hi:icvd_b_refr_lo], icvd_refr_low_zero};
        end else begin
            refr_cnt_reg <= refr_cnt_next;
        end
    end

    // the reload on expiry keeps this a single-cycle pulse per period
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            refresh_request <= 1'b0;
        end else begin
            refresh_request <= refr_expire; // [R24]
        end
    end
endmodule

// >>> icvd_host_model.sv
// host software model driving the init register port and the config write gate
// assumes clk comes from the bench; strobes change at the falling edge only
`timescale 1ns/1ps
module icvd_host_model (
    // clock
    input wire logic clk,
    // register port
    output logic host_wr,
    output logic host_rd,
    output logic host_sel,
    output logic [31:0] host_wdata,
    output logic init_register_write_gate
);
    initial begin
        {host_wr, host_rd, host_sel, init_register_write_gate} = 4'h0;
        host_wdata = 32'h0000_0000;
    end
    // left high so a following call gives a back-to-back write; nothing is queued
    task automatic wr(input logic sel, input logic [31:0] d, input logic gate);
        @(negedge clk);
        host_wr = 1'b1;
        host_rd = 1'b0;
        host_sel = sel;
        host_wdata = d;
        init_register_write_gate = gate;
    endtask
    task automatic rd(input logic sel);
        @(negedge clk);
        host_wr = 1'b0;
        host_rd = 1'b1;
        host_sel = sel;
        host_wdata = ~host_wdata; // released data bus does not keep the old word
        @(negedge clk);
        host_rd = 1'b0;
    endtask
endmodule

// >>> icvd_init_config_props.sv
// checker for the init register bank, watching top-level ports only
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/1ps
module icvd_init_config_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // host port
    input wire logic host_wr,
    input wire logic host_sel,
    input wire logic [31:0] host_wdata,
    input wire logic init_register_write_gate,
    // field outputs
    input wire logic pci_write_wait,
    input wire logic lfb_read_enable,
    input wire logic [3:0] tiles_x_half,
    input wire logic hsync_out,
    input wire logic blank_out,
    input wire logic video_data_oe,
    input wire logic blank_oe,
    input wire logic sync_oe,
    input wire logic dot_clock_oe,
    input wire logic fast_raw_turnaround,
    input wire logic gen_oe_enable,
    input wire logic [1:0] swap_source,
    input wire logic [8:0] video_buffer_offset,
    input wire logic refresh_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire wr0 = host_wr && init_register_write_gate && !host_sel;
    wire wr1 = host_wr && init_register_write_gate && host_sel;
    property p_gate; !(host_wr && init_register_write_gate) |-> ##2 $stable(tiles_x_half);
    endproperty
    a_gate: assert property (p_gate) else $error("field moved without a write");
    property p_wait; wr0 |-> ##2 pci_write_wait == $past(host_wdata[1], 2); endproperty
    a_wait: assert property (p_wait) else $error("wait state copy wrong");
    property p_lfb; wr0 |-> ##2 {tiles_x_half, lfb_read_enable} == $past(host_wdata[7:3], 2);
    endproperty
    a_lfb: assert property (p_lfb) else $error("read enable or tiles wrong");
    property p_sync; wr0 && host_wdata[9] ##1 !wr0 |-> ##1 hsync_out == $past(host_wdata[10], 2);
    endproperty
    a_sync: assert property (p_sync) else $error("sync override ignored");
    property p_blank; wr0 && host_wdata[12] |-> ##2 blank_out; endproperty
    a_blank: assert property (p_blank) else $error("software blank ignored");
    property p_oe;
        wr0 |-> ##2 {dot_clock_oe, sync_oe, blank_oe, video_data_oe}
            == $past(host_wdata[16:13], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("output enables wrong");
    property p_raw; fast_raw_turnaround |-> gen_oe_enable; endproperty
    a_raw: assert property (p_raw) else $error("turnaround without oe");
    property p_dram;
        wr1 |-> ##2 {video_buffer_offset, swap_source} == $past(host_wdata[19:9], 2);
    endproperty
    a_dram: assert property (p_dram) else $error("offset or swap source wrong");
    c_ovr: cover property (wr0 && host_wdata[9]);
    c_refr: cover property (refresh_request);
    c_block: cover property (host_wr && !init_register_write_gate);
endmodule
bind icvd_init_config icvd_init_config_props icvd_init_config_props_inst (.*);

// >>> tb.sv
// self-checking bench: host model drives the registers, a bench model predicts each result
// assumes design, package, host model and checker are compiled before it
`timescale 1ns/1ps
module tb;
    import icvd_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic host_wr, host_rd, host_sel, init_register_write_gate;
    logic [31:0] host_wdata, host_rdata, pvi_m, dram_m, d;
    logic [31:0] st = 32'd14;
    logic func_strap_pin = 1'b1;
    logic multi_chip_pin = 1'b1;
    logic timing_hsync = 1'b0, timing_vsync = 1'b0, timing_blank = 1'b0;
    logic pci_write_wait, lfb_read_enable, no_fast_rar_turnaround, video_timing_reset;
    logic hsync_out, vsync_out, blank_out, video_data_oe, blank_oe, sync_oe, dot_clock_oe;
    logic vclk_input_slave, invert_double_rate_video_clock, bpp24_enable, interleave_enable;
    logic edge_filter_enable, dither_subtract_enable, bank_size_256k, triple_buffer_enable;
    logic fast_ras_enable, gen_oe_enable, fast_raw_turnaround, pass_dither_enable;
    logic bank_enable, read_ahead_fifo_enable, refresh_request;
    logic [3:0] tiles_x_half;
    logic [1:0] vclk_source, double_rate_video_clock_delay, selected_double_rate_clock_delay;
    logic [1:0] video_clock_delay, swap_source;
    logic [8:0] video_buffer_offset;
    int err_total = 0;
    int check_count = 0;
    int n;
    icvd_init_config icvd_init_config_inst (.*);
    icvd_host_model icvd_host_model_inst (.*);
    always #4 clk = ~clk;
    always @(negedge clk) begin
        {timing_blank, timing_vsync, timing_hsync} <=
            {timing_blank, timing_vsync, timing_hsync} + 3'h1;
    end
    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic do_wr(input logic sel, input logic [31:0] v, input logic g);
        icvd_host_model_inst.wr(sel, v, g);
        if (g && !sel) pvi_m = v;
        if (g && sel) dram_m = v;
    endtask
    // read back one register, then compare every field output of both
    task automatic check(input logic sel);
        icvd_host_model_inst.rd(sel);
        if (sel) chk(host_rdata, dram_m & 32'hffff_fff3);
        else chk(host_rdata, (pvi_m & 32'hfeff_fffa)
            | {29'h0, multi_chip_pin, 1'b0, func_strap_pin});
        // timing inputs still hold the value the last rising edge saw
        chk(32'({blank_out, vsync_out, hsync_out}), 32'({pvi_m[12] | timing_blank,
            pvi_m[9] ? pvi_m[11:10] : {timing_vsync, timing_hsync}}));
        chk({no_fast_rar_turnaround, video_clock_delay, selected_double_rate_clock_delay,
            invert_double_rate_video_clock, edge_filter_enable, 1'b0, interleave_enable,
            bpp24_enable, vclk_source, double_rate_video_clock_delay, vclk_input_slave,
            dot_clock_oe, sync_oe, blank_oe, video_data_oe, 4'h0, video_timing_reset,
            tiles_x_half, lfb_read_enable, 1'b0, pci_write_wait, 1'b0},
            pvi_m & 32'hfeff_e1fa);
        chk({10'h000, read_ahead_fifo_enable, bank_enable, video_buffer_offset, swap_source,
            pass_dither_enable, fast_raw_turnaround, gen_oe_enable, fast_ras_enable,
            triple_buffer_enable, 2'h0, bank_size_256k, dither_subtract_enable},
            dram_m & 32'h003f_fff3);
    endtask
    task automatic wait_pulse(output int cnt, input int lim);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (refresh_request !== 1'b1 && cnt < lim);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        pvi_m = 32'h0020_1102;
        dram_m = 32'h8000_0040;
        check(1'b0);
        check(1'b1);
        $display("test reset values done");
        for (int i = 0; i < 40; i++) begin
            d = xs();
            d[7] = d[7] & d[6];
            do_wr(st[8], d, st[3] | st[4]);
            d = xs();
            d[7] = d[7] & d[6];
            do_wr(~st[9], d, 1'b1);
            check(1'b0);
            check(1'b1);
        end
        multi_chip_pin = 1'b0;
        repeat (3) @(negedge clk);
        check(1'b0);
        $display("test random writes done");
        // park the timer first: a random earlier load may still be counting down
        do_wr(1'b1, 32'h0080_0040, 1'b1);
        do_wr(1'b1, 32'h00c0_0040, 1'b1);
        check(1'b1);
        wait_pulse(n, 500);
        wait_pulse(n, 500);
        chk(32'(n), 32'd33);
        do_wr(1'b1, 32'h0080_0040, 1'b1);
        check(1'b1);
        repeat (3) @(negedge clk);
        wait_pulse(n, 100);
        chk(32'(n), 32'd100);
        $display("test refresh done");
        func_strap_pin = 1'b0;
        reset_n = 1'b0;
        repeat (20) @(negedge clk);
        chk(32'({blank_out, refresh_request}), 32'h0000_0002);
        reset_n = 1'b1;
        pvi_m = 32'h0020_1102;
        dram_m = 32'h8000_0040;
        check(1'b0);
        check(1'b1);
        $display("test second reset done");
        finish_test();
    end
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
endmodule
